/* File: hw/spmp_cfg.svh */
// Constants of the serial memory programming port.
// Assumes a core clock of 100 MHz; included by bare name.
`ifndef SPMP_CFG_SVH
`define SPMP_CFG_SVH
`define SPMP_CLK_PERIOD_NS  10
`define SPMP_FLASH_WAIT_NS  4500000
`define SPMP_EEPROM_WAIT_NS 9000000
`define SPMP_ERASE_WAIT_NS  9000000
`define SPMP_BUSY_W         20
`define SPMP_ERASED_BYTE    8'hff
`define SPMP_CMD_ENABLE     8'hac
`define SPMP_ENABLE_KEY     8'h53
`define SPMP_ERASE_KEY      3'h4
`define SPMP_CMD_RD_FLASH   4'h2
`define SPMP_CMD_LD_PAGE    4'h4
`define SPMP_CMD_WR_PAGE    8'h4c
`define SPMP_CMD_RD_EEPROM  8'ha0
`define SPMP_CMD_WR_EEPROM  8'hc0
`define SPMP_FLASH_AW       13
`define SPMP_EEPROM_AW      9
`define SPMP_PAGE_AW        6
`define SPMP_FLASH_LAST     13'h1fff
`define SPMP_PAGE_LAST      6'h3f
`endif

/* File: hw/spmp_pkg.sv */
// Types shared by the serial memory programming port.
// Assumes nothing of its surroundings.
package spmp_pkg;
  typedef enum logic [1:0] {
    SPMP_IDLE,
    SPMP_FLASH,
    SPMP_EEPROM,
    SPMP_ERASE
  } spmp_busy_e;
  typedef enum logic [1:0] {
    SPMP_RD_ECHO,
    SPMP_RD_FL,
    SPMP_RD_EE
  } spmp_rd_e;
endpackage

/* File: hw/spmp_mem.sv */
// Byte memory with one write port and a registered read port.
// Assumes one clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module spmp_mem #(
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_reg [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_reg[raddr];
    end
  end
endmodule // spmp_mem
`default_nettype wire

/* File: hw/spmp_port.sv */
// Serial programming port: four-byte instructions over SCK/MOSI/MISO.
// Assumes pins are asynchronous to clock and the programmer obeys SCK
// phase limits; Flash and EEPROM arrays live inside this block.
// What this block does
// - Programming works only while the device reset pin is held low.
// - Program and erase are refused until programming enable is accepted.
// - Chip erase sets every Flash and EEPROM byte to 0xff.
// - MOSI is sampled on each rising SCK edge.
// - MISO is shifted on each falling SCK edge except the first after a byte boundary.
// - Second enable byte 0x53 is echoed during the third byte.
// - Page load carries five word address bits and one data byte.
// - Page write commits the buffer to the page in seven bits.
// - EEPROM bytes are written singly, overwriting the location with no separate erase.
// - Reads return the addressed byte on MISO in the last byte.
// - Releasing reset ends programming and starts normal operation.
// - Reads inside a programming Flash page return 0xff until done.
// - Enable is 0xac, 0x53, then two don't-care bytes.
// - Reads of a programming EEPROM byte return 0xff until done.
`include "spmp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spmp_port import spmp_pkg::*; #(
  parameter int FLASH_WAIT  = `SPMP_FLASH_WAIT_NS / `SPMP_CLK_PERIOD_NS,
  parameter int EEPROM_WAIT = `SPMP_EEPROM_WAIT_NS / `SPMP_CLK_PERIOD_NS,
  parameter int ERASE_WAIT  = `SPMP_ERASE_WAIT_NS / `SPMP_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Programming pins
  input  wire logic dev_reset_n,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // Status
  output logic      prog_mode,
  output logic      busy,
  output logic      core_run
);
  logic [1:0]               rst_sy_reg;
  logic [1:0]               sck_sy_reg;
  logic [1:0]               mosi_sy_reg;
  logic                     sck_d_reg;
  logic                     session;
  logic                     sck_rise;
  logic                     sck_fall;
  logic [4:0]               bit_cnt_reg;
  logic [31:0]              rx_reg;
  logic                     byte_p_reg;
  logic                     exec_p_reg;
  logic                     rd_p_reg;
  logic [1:0]               ld_pipe_reg;
  logic [7:0]               echo_reg;
  logic [7:0]               out_reg;
  logic [7:0]               ld_byte;
  logic                     prog_en_reg;
  logic                     miso_oe_reg;
  logic                     core_run_reg;
  logic                     cmd_ok;
  logic                     do_erase;
  logic                     do_load;
  logic                     do_commit;
  logic                     do_eewr;
  spmp_busy_e               kind_reg;
  logic [`SPMP_BUSY_W-1:0]  wait_reg;
  logic                     busy_reg;
  logic [6:0]               page_reg;
  logic [8:0]               ee_addr_reg;
  logic                     ers_run_reg;
  logic [12:0]              ers_addr_reg;
  logic                     cp_run_reg;
  logic [5:0]               cp_addr_reg;
  logic                     cp_wr_reg;
  logic [5:0]               cp_waddr_reg;
  spmp_rd_e                 rd_kind_reg;
  logic                     rd_mask_reg;
  logic [12:0]              fl_raddr_reg;
  logic [8:0]               ee_raddr_reg;
  logic                     fl_we;
  logic [12:0]              fl_waddr;
  logic [7:0]               fl_wdata;
  logic [7:0]               fl_q;
  logic                     ee_we;
  logic [8:0]               ee_waddr;
  logic [7:0]               ee_wdata;
  logic [7:0]               ee_q;
  logic [7:0]               buf_q;

  // Pins are asynchronous; each passes two flops before use.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sy_reg  <= 2'h3;
      sck_sy_reg  <= 2'h0;
      mosi_sy_reg <= 2'h0;
      sck_d_reg   <= 1'b0;
    end else begin
      rst_sy_reg  <= {rst_sy_reg[0], dev_reset_n};
      sck_sy_reg  <= {sck_sy_reg[0], sck};
      mosi_sy_reg <= {mosi_sy_reg[0], mosi};
      sck_d_reg   <= sck_sy_reg[1];
    end
  end

  assign session  = !rst_sy_reg[1];
  assign sck_rise = session && sck_sy_reg[1] && !sck_d_reg;
  assign sck_fall = session && !sck_sy_reg[1] && sck_d_reg;

  // Framing restarts whenever reset is released, which resynchronises.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 5'h00;
      rx_reg      <= 32'h0000_0000;
    end else if (!session) begin
      bit_cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      rx_reg      <= {rx_reg[30:0], mosi_sy_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_p_reg  <= 1'b0;
      exec_p_reg  <= 1'b0;
      rd_p_reg    <= 1'b0;
      ld_pipe_reg <= 2'h0;
    end else begin
      byte_p_reg  <= sck_rise && (bit_cnt_reg[2:0] == 3'h7);
      exec_p_reg  <= sck_rise && (bit_cnt_reg == 5'h1f);
      rd_p_reg    <= sck_rise && (bit_cnt_reg == 5'h17);
      ld_pipe_reg <= {ld_pipe_reg[0], byte_p_reg};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_en_reg <= 1'b0;
    end else if (!session) begin
      prog_en_reg <= 1'b0;
    end else if (exec_p_reg && (rx_reg[31:24] == `SPMP_CMD_ENABLE) &&
                 (rx_reg[23:16] == `SPMP_ENABLE_KEY)) begin
      prog_en_reg <= 1'b1;
    end
  end

  assign cmd_ok    = exec_p_reg && prog_en_reg && (kind_reg == SPMP_IDLE);
  assign do_erase  = cmd_ok && (rx_reg[31:24] == `SPMP_CMD_ENABLE) &&
                     (rx_reg[23:21] == `SPMP_ERASE_KEY);
  assign do_load   = cmd_ok && (rx_reg[31:28] == `SPMP_CMD_LD_PAGE) &&
                     (rx_reg[26:24] == 3'h0);
  assign do_commit = cmd_ok && (rx_reg[31:24] == `SPMP_CMD_WR_PAGE);
  assign do_eewr   = cmd_ok && (rx_reg[31:24] == `SPMP_CMD_WR_EEPROM);

  // New writes are ignored while one is self-timing, which protects it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg <= SPMP_IDLE;
      wait_reg <= '0;
      busy_reg <= 1'b0;
    end else if (do_erase) begin
      kind_reg <= SPMP_ERASE;
      wait_reg <= `SPMP_BUSY_W'(ERASE_WAIT);
      busy_reg <= 1'b1;
    end else if (do_commit) begin
      kind_reg <= SPMP_FLASH;
      wait_reg <= `SPMP_BUSY_W'(FLASH_WAIT);
      busy_reg <= 1'b1;
    end else if (do_eewr) begin
      kind_reg <= SPMP_EEPROM;
      wait_reg <= `SPMP_BUSY_W'(EEPROM_WAIT);
      busy_reg <= 1'b1;
    end else if (kind_reg != SPMP_IDLE) begin
      if (wait_reg > `SPMP_BUSY_W'(1)) begin
        wait_reg <= wait_reg - `SPMP_BUSY_W'(1);
      end else if (!ers_run_reg && !cp_run_reg && !cp_wr_reg) begin
        kind_reg <= SPMP_IDLE;
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_reg    <= 7'h00;
      ee_addr_reg <= 9'h000;
    end else begin
      if (do_commit) begin
        page_reg <= rx_reg[19:13];
      end
      if (do_eewr) begin
        ee_addr_reg <= rx_reg[16:8];
      end
    end
  end

  // Erase sweeps the whole Flash; EEPROM shares the low addresses.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ers_run_reg  <= 1'b0;
      ers_addr_reg <= 13'h0000;
    end else if (do_erase) begin
      ers_run_reg  <= 1'b1;
      ers_addr_reg <= 13'h0000;
    end else if (ers_run_reg) begin
      ers_addr_reg <= ers_addr_reg + 13'h0001;
      if (ers_addr_reg == `SPMP_FLASH_LAST) begin
        ers_run_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cp_run_reg   <= 1'b0;
      cp_addr_reg  <= 6'h00;
      cp_wr_reg    <= 1'b0;
      cp_waddr_reg <= 6'h00;
    end else begin
      cp_wr_reg    <= cp_run_reg;
      cp_waddr_reg <= cp_addr_reg;
      if (do_commit) begin
        cp_run_reg  <= 1'b1;
        cp_addr_reg <= 6'h00;
      end else if (cp_run_reg) begin
        cp_addr_reg <= cp_addr_reg + 6'h01;
        if (cp_addr_reg == `SPMP_PAGE_LAST) begin
          cp_run_reg <= 1'b0;
        end
      end
    end
  end

  assign fl_we    = ers_run_reg || cp_wr_reg;
  assign fl_waddr = ers_run_reg ? ers_addr_reg : {page_reg, cp_waddr_reg};
  assign fl_wdata = ers_run_reg ? `SPMP_ERASED_BYTE : buf_q;
  assign ee_we    = (ers_run_reg && (ers_addr_reg[12:9] == 4'h0)) || do_eewr;
  assign ee_waddr = ers_run_reg ? ers_addr_reg[8:0] : rx_reg[16:8];
  assign ee_wdata = ers_run_reg ? `SPMP_ERASED_BYTE : rx_reg[7:0];

  spmp_mem #(.AW(`SPMP_PAGE_AW)) u_page_buf (
    .clock (clock),
    .rst_n (rst_n),
    .we    (do_load),
    .waddr ({rx_reg[12:8], rx_reg[27]}),
    .wdata (rx_reg[7:0]),
    .raddr (cp_addr_reg),
    .rdata (buf_q)
  );

  spmp_mem #(.AW(`SPMP_FLASH_AW)) u_flash (
    .clock (clock),
    .rst_n (rst_n),
    .we    (fl_we),
    .waddr (fl_waddr),
    .wdata (fl_wdata),
    .raddr (fl_raddr_reg),
    .rdata (fl_q)
  );

  spmp_mem #(.AW(`SPMP_EEPROM_AW)) u_eeprom (
    .clock (clock),
    .rst_n (rst_n),
    .we    (ee_we),
    .waddr (ee_waddr),
    .wdata (ee_wdata),
    .raddr (ee_raddr_reg),
    .rdata (ee_q)
  );

  // Read address is taken after the third byte; data goes out in the fourth.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_kind_reg  <= SPMP_RD_ECHO;
      rd_mask_reg  <= 1'b0;
      fl_raddr_reg <= 13'h0000;
      ee_raddr_reg <= 9'h000;
    end else if (rd_p_reg && prog_en_reg &&
                 (rx_reg[23:20] == `SPMP_CMD_RD_FLASH) &&
                 (rx_reg[18:16] == 3'h0)) begin
      rd_kind_reg  <= SPMP_RD_FL;
      fl_raddr_reg <= {rx_reg[11:0], rx_reg[19]};
      rd_mask_reg  <= (kind_reg == SPMP_ERASE) ||
                      ((kind_reg == SPMP_FLASH) &&
                       (rx_reg[11:5] == page_reg));
    end else if (rd_p_reg && prog_en_reg &&
                 (rx_reg[23:16] == `SPMP_CMD_RD_EEPROM)) begin
      rd_kind_reg  <= SPMP_RD_EE;
      ee_raddr_reg <= {rx_reg[8], rx_reg[7:0]};
      rd_mask_reg  <= (kind_reg == SPMP_ERASE) ||
                      ((kind_reg == SPMP_EEPROM) &&
                       ({rx_reg[8], rx_reg[7:0]} == ee_addr_reg));
    end else if (byte_p_reg) begin
      rd_kind_reg <= SPMP_RD_ECHO;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      echo_reg <= 8'h00;
    end else if (byte_p_reg) begin
      echo_reg <= rx_reg[7:0];
    end
  end

  always_comb begin
    unique case (rd_kind_reg)
      SPMP_RD_ECHO: ld_byte = echo_reg;
      SPMP_RD_FL:   ld_byte = rd_mask_reg ? `SPMP_ERASED_BYTE : fl_q;
      SPMP_RD_EE:   ld_byte = rd_mask_reg ? `SPMP_ERASED_BYTE : ee_q;
      default:      ld_byte = echo_reg;
    endcase
  end

  // The fall right after a byte boundary keeps the freshly loaded MSB.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 8'h00;
    end else if (!session) begin
      out_reg <= 8'h00;
    end else if (ld_pipe_reg[1]) begin
      out_reg <= ld_byte;
    end else if (sck_fall && (bit_cnt_reg[2:0] != 3'h0)) begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      miso_oe_reg  <= 1'b0;
      core_run_reg <= 1'b0;
    end else begin
      miso_oe_reg  <= session;
      core_run_reg <= !session;
    end
  end

  assign miso      = out_reg[7];
  assign miso_oe   = miso_oe_reg;
  assign prog_mode = prog_en_reg;
  assign busy      = busy_reg;
  assign core_run  = core_run_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_erase_sweep;
    (ers_run_reg && fl_we && (fl_wdata == `SPMP_ERASED_BYTE))[*8];
  endsequence

  a_prog_only_low: assert property (
    !session |=> !prog_mode)
    else $error("programming mode outside reset low");
  a_enable_first: assert property (
    exec_p_reg && !prog_en_reg && (kind_reg == SPMP_IDLE)
    |=> (kind_reg == SPMP_IDLE))
    else $error("operation accepted before enable");
  a_erase_fills: assert property (
    do_erase |=> s_erase_sweep)
    else $error("chip erase does not write 0xff");
  a_mosi_rise: assert property (
    sck_rise |=> (rx_reg[0] == $past(mosi_sy_reg[1])))
    else $error("MOSI not sampled on rising SCK");
  a_miso_fall: assert property (
    sck_fall && (bit_cnt_reg[2:0] != 3'h0) && !ld_pipe_reg[1]
    |=> (out_reg == {$past(out_reg[6:0]), 1'b0}))
    else $error("MISO not shifted on falling SCK");
  a_enable_echo: assert property (
    byte_p_reg && (bit_cnt_reg == 5'h10) && session &&
    (rx_reg[15:8] == `SPMP_CMD_ENABLE) &&
    (rx_reg[7:0] == `SPMP_ENABLE_KEY)
    ##3 session |-> (out_reg == `SPMP_ENABLE_KEY))
    else $error("enable key not echoed");
  a_commit_page: assert property (
    do_commit |=> cp_run_reg && (page_reg == $past(rx_reg[19:13])))
    else $error("page write not started");
  a_ee_write: assert property (
    do_eewr |=> (kind_reg == SPMP_EEPROM) &&
    (ee_addr_reg == $past(rx_reg[16:8])))
    else $error("EEPROM write not started");
  a_read_data: assert property (
    ld_pipe_reg[1] && session && (rd_kind_reg == SPMP_RD_FL) &&
    !rd_mask_reg |=> (out_reg == $past(fl_q)))
    else $error("read data not loaded");
  a_flash_mask: assert property (
    ld_pipe_reg[1] && session && (rd_kind_reg == SPMP_RD_FL) &&
    rd_mask_reg |=> (out_reg == `SPMP_ERASED_BYTE))
    else $error("busy Flash page not read as 0xff");
  a_ee_mask: assert property (
    ld_pipe_reg[1] && session && (rd_kind_reg == SPMP_RD_EE) &&
    rd_mask_reg |=> (out_reg == `SPMP_ERASED_BYTE))
    else $error("busy EEPROM byte not read as 0xff");
  a_run_after: assert property (
    !session |=> core_run)
    else $error("normal operation not resumed");
endmodule // spmp_port
`default_nettype wire

/* File: testbench/spmp_prog_model.sv */
// Programmer model: drives the serial programming pins as an SPI mode 0
// master. Assumes the bench clock; every pin changes at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module spmp_prog_model #(
  parameter int HALF_CLKS  = 6,
  parameter int START_CLKS = 20
) (
  // Clock
  input  wire logic        clock,
  // Programming pins
  output logic             dev_reset_n,
  output logic             sck,
  output logic             mosi,
  input  wire logic        miso,
  // Answer to the bench
  output logic             rx_valid,
  output logic [31:0]      rx_word
);
  initial begin
    dev_reset_n = 1'b0;
    sck         = 1'b0;
    mosi        = 1'b0;
    rx_valid    = 1'b0;
    rx_word     = 32'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask

  // A low level waits a scaled settling time before the first instruction.
  task automatic set_reset(input logic lvl);
    dev_reset_n = lvl;
    wait_clk(lvl ? 6 : START_CLKS);
  endtask

  // SCK only runs inside an instruction; MISO is taken as SCK rises.
  task automatic run(input logic [31:0] w);
    logic [31:0] got;
    got = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      // Low phases alternate 6 and 7 clocks for a mean 125 ns SCK period.
      wait_clk(HALF_CLKS + i[0]);
      sck = 1'b1;
      got[i] = miso;
      wait_clk(HALF_CLKS);
      sck = 1'b0;
    end
    // An idle MOSI shows no stale bit, so a late sample cannot pass.
    mosi     = ~w[0];
    rx_word  = got;
    rx_valid = 1'b1;
    wait_clk(1);
    rx_valid = 1'b0;
  endtask
endmodule // spmp_prog_model
`default_nettype wire

/* File: testbench/serial_memory_programming_port_tb.sv */
// Self-checking bench of the serial programming port.
// Assumes the programmer model drives the pins; waits are shortened.
`timescale 1ns/1ps
`default_nettype none
module serial_memory_programming_port_tb;
  localparam int FLASH_WAIT  = 2000;
  localparam int EEPROM_WAIT = 3000;
  localparam int ERASE_WAIT  = 9000;
  logic        clock;
  logic        rst_n;
  logic        dev_reset_n;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        prog_mode;
  logic        busy;
  logic        core_run;
  logic        rx_valid;
  logic [31:0] rx_word;
  logic [63:0] exp_q[$];
  int          n_errors;
  int          compares;
  logic [31:0] rng;
  logic [6:0]  pg;
  logic [4:0]  wd;
  logic [7:0]  fd[4];
  logic [8:0]  ea;
  logic [7:0]  ed;

  spmp_port #(
    .FLASH_WAIT  (FLASH_WAIT),
    .EEPROM_WAIT (EEPROM_WAIT),
    .ERASE_WAIT  (ERASE_WAIT)
  ) dut (
    .clock(clock), .rst_n(rst_n), .dev_reset_n(dev_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode),
    .busy(busy), .core_run(core_run));

  spmp_prog_model prog (
    .clock(clock), .dev_reset_n(dev_reset_n), .sck(sck), .mosi(mosi),
    .miso(miso_oe ? miso : ~miso), .rx_valid(rx_valid), .rx_word(rx_word));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic fail(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic chk_flag(input logic got, input logic want, input string s);
    compares++;
    if (got !== want) fail(s);
  endtask

  task automatic chk_byte(input logic [31:0] got, input logic [63:0] note);
    compares++;
    if ((got & note[63:32]) !== note[31:0])
      fail($sformatf("answer %h, wanted %h", got, note[31:0]));
  endtask

  // Notes the answer bits that matter, then sends the instruction.
  task automatic instr(input logic [31:0] w, input logic [31:0] mask,
                       input logic [31:0] want);
    exp_q.push_back({mask, want});
    prog.run(w);
  endtask

  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("answer without a note");
      else if (exp_q[0][63:32] != 32'h0) chk_byte(rx_word, exp_q.pop_front());
      else void'(exp_q.pop_front());
    end
  end

  task automatic enable();
    instr({8'hac, 8'h53, 16'h0}, 32'hff00, 32'h5300);
  endtask

  task automatic rd_flash(input logic [11:0] wa, input logic h,
                          input logic [7:0] d);
    instr({4'h2, h, 3'h0, 4'h0, wa, 8'h00}, 32'hff, {24'h0, d});
  endtask

  task automatic rd_ee(input logic [8:0] a, input logic [7:0] d);
    instr({8'ha0, 7'h0, a, 8'h00}, 32'hff, {24'h0, d});
  endtask

  task automatic wr_ee(input logic [8:0] a, input logic [7:0] d);
    instr({8'hc0, 7'h0, a, d}, 32'h0, 32'h0);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    if (busy !== 1'b0) fail("busy never fell");
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    fail("watchdog ran out");
    test_done();
  end

  initial begin
    rst_n    = 1'b0;
    n_errors = 0;
    compares = 0;
    rng      = 32'd48432;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    // Pin high: normal operation, the port ignores instructions.
    prog.set_reset(1'b1);
    chk_flag(core_run, 1'b1, "core not running");
    chk_flag(miso_oe, 1'b0, "miso driven outside session");
    wr_ee(9'h0, 8'h00);
    chk_flag(busy, 1'b0, "write taken outside session");
    $display("test outside_session done");
    prog.set_reset(1'b0);
    chk_flag(miso_oe, 1'b1, "miso not driven in session");
    chk_flag(core_run, 1'b0, "core runs in session");
    wr_ee(9'h0, 8'h00);
    chk_flag(busy, 1'b0, "write taken before enable");
    instr({8'hac, 8'h80, 16'h0}, 32'h0, 32'h0);
    chk_flag(busy, 1'b0, "erase taken before enable");
    enable();
    chk_flag(prog_mode, 1'b1, "enable refused");
    $display("test enable done");
    instr({8'hac, 8'h80, 16'h0}, 32'h0, 32'h0);
    chk_flag(busy, 1'b1, "erase not started");
    wait_idle();
    for (int k = 0; k < 3; k++) begin
      rd_flash(12'(next_rand()), rng[12], 8'hff);
      rd_ee(9'(next_rand()), 8'hff);
    end
    $display("test erase done");
    pg = 7'(next_rand());
    for (int k = 0; k < 4; k++) begin
      wd    = k[1] ? 5'h1f : 5'h00;
      fd[k] = 8'(next_rand());
      instr({4'h4, k[0], 3'h0, 8'h00, 3'h0, wd, fd[k]}, 0, 0);
    end
    instr({8'h4c, 4'h0, pg[6:3], pg[2:0], 5'h0, 8'h00}, 0, 0);
    chk_flag(busy, 1'b1, "page write not started");
    rd_flash({pg, 5'h1f}, 1'b0, 8'hff);
    wait_idle();
    for (int k = 0; k < 4; k++)
      rd_flash({pg, k[1] ? 5'h1f : 5'h00}, k[0], fd[k]);
    $display("test flash page done");
    ea = 9'(next_rand());
    ed = {1'b0, rng[14:8]};
    wr_ee(ea, ed);
    chk_flag(busy, 1'b1, "eeprom write not started");
    rd_ee(ea, 8'hff);
    rd_ee(ea, 8'hff);
    wait_idle();
    rd_ee(ea, ed);
    rd_ee(ea ^ 9'h1, 8'hff);
    ed = ed ^ 8'h0f;
    wr_ee(ea, ed);
    wait_idle();
    rd_ee(ea, ed);
    $display("test eeprom done");
    prog.set_reset(1'b1);
    chk_flag(prog_mode, 1'b0, "session kept after release");
    chk_flag(core_run, 1'b1, "core not restarted");
    prog.set_reset(1'b0);
    enable();
    chk_flag(prog_mode, 1'b1, "resync refused");
    rd_ee(ea, ed);
    rd_flash({pg, 5'h00}, 1'b1, fd[1]);
    $display("test resync done");
    test_done();
  end
endmodule // serial_memory_programming_port_tb
`default_nettype wire
